// ==== logic/gear_filter_map.svh ====
/*
  Register offsets, reset values, legal ranges and timing counts of the
  pulse command gear filter. Assumes a 25 MHz reference clock.
*/
`ifndef GEAR_FILTER_MAP_SVH
`define GEAR_FILTER_MAP_SVH

// ************************************************
// register byte offsets
// ************************************************
`define GF_REG_NUM 8'h00
`define GF_REG_DEN 8'h04
`define GF_REG_PPR 8'h08
`define GF_REG_SW 8'h0C
`define GF_REG_JERK 8'h10
`define GF_REG_LP 8'h14
`define GF_REG_INTERP 8'h18
`define GF_REG_PFW 8'h1C
`define GF_REG_COUNT 8'h20
`define GF_REG_CMD 8'h24
`define GF_REG_STAT 8'h28

// ************************************************
// reset values and legal ranges
// ************************************************
`define GF_RST_NUM 32'h0010_0000
`define GF_RST_DEN 32'h0000_2710
`define GF_RST_PPR 32'h0000_2710
`define GF_RST_TC 16'h000A
`define GF_RST_PFW 16'h0002
`define GF_RATIO_MIN 32'h0000_0001
`define GF_RATIO_MAX 32'h7FFF_FFFF
`define GF_PPR_MIN 32'h0000_00C8
`define GF_PPR_MAX 32'h0002_0000
`define GF_JERK_MAX 16'h00FA
`define GF_LP_MAX 16'h03E8
`define GF_INTERP_MAX 16'h00FA
`define GF_PFW_MAX 16'h7D00
`define GF_UNITS_PER_REV 32'h0010_0000

// ************************************************
// timing
// ************************************************
`define GF_CLK_NS 32'h0000_0028
`define GF_WIDTH_STEP_NS 32'h0000_0064
`define GF_MS_NS 32'h000F_4240
`define GF_MS_CYCLES (`GF_MS_NS / `GF_CLK_NS)

`endif

// ==== logic/gear_filter_pkg.sv ====
/*
  Types of the pulse command gear filter.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package gear_filter_pkg;
  typedef enum logic [1:0] {
    MODE_PULSE = 2'h0,
    MODE_TRAJ = 2'h1,
    MODE_OTHER = 2'h3
  } ctrl_mode_type;
  typedef enum logic [1:0] {
    DIV_IDLE = 2'h0,
    DIV_RUN = 2'h1,
    DIV_DONE = 2'h3
  } div_state_type;
endpackage
`default_nettype wire

// ==== logic/pulse_command_gear_filter.sv ====
/*
  Command pulse noise filter, gear scaling and command smoothing.
  Assumes a classic Wishbone master on ref_clk_i, pulse and direction
  pins from the host controller, and mode/trajectory inputs from logic
  on the same clock.
*/
// Local design decisions: the address map and the Wishbone slave port.
// How it works
// [R1] pulse phases shorter than the filter width never reach the counter
// [R2] filter width is counted in steps of 0.1 us
// [R3] host keeps filter width at most 1/(A x pulse frequency), A 4 or 5
// [R4] switch 0: pulses-per-rev sets scaling, gear ratio ignored
// [R5] switch 0: reported position reads pulses-per-rev counts per turn
// [R6] switch 1: gear ratio used, one turn is 1048576 units
// [R7] switch 1: command grows by pulses times numerator over denominator
// [R8] switch 1: reported position reads 1048576 x den / num per turn
// [R9] numerator takes 1 to 2147483647, resets to 1048576
// [R10] denominator takes 1 to 2147483647, resets to 10000
// [R11] pulses-per-rev takes 200 to 131072, resets to 10000
// [R12] gear switch takes 0 or 1, resets to 0
// [R13] smoothing constants in ms; zero bypasses the stage
// [R14] jerk stage acts in trajectory mode, 0 to 250 ms, reset 10
// [R15] low-pass stage always acts, 0 to 1000 ms, reset 10
// [R16] interpolation stage acts on pulse commands, 0 to 250 ms, reset 10
// [R17] interpolation stage only in external pulse position mode
// [R18] division remainder carried between pulses, no drift
// [R19] phase counter on the clock passes an edge after full width
`timescale 1ns/10ps
`default_nettype none
`include "gear_filter_map.svh"
module pulse_command_gear_filter #(
  parameter int MS_CYCLES = `GF_MS_CYCLES,
  parameter int POS_W = 32,
  parameter int PEND_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pulse_i,
  input wire logic dir_i,
  input wire gear_filter_pkg::ctrl_mode_type ctrl_mode_i,
  input wire logic [POS_W-1:0] traj_pos_i,
  output logic filt_pulse_o,
  output logic filt_dir_o,
  output logic [POS_W-1:0] gear_pos_o,
  output logic [POS_W-1:0] cmd_pos_o,
  output logic [31:0] pulse_count_o
);
  import gear_filter_pkg::*;

  localparam int TW = $clog2(MS_CYCLES + 1);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic in_rng(input logic [31:0] v,
                                  input logic [31:0] lo,
                                  input logic [31:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // ************************************************
  // wishbone slave
  // ************************************************
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_data;
  logic req;
  logic wr;
  logic [31:0] num_q;
  logic [31:0] den_q;
  logic [31:0] ppr_q;
  logic sw_q;
  logic [15:0] jerk_q;
  logic [15:0] lp_q;
  logic [15:0] interp_q;
  logic [15:0] pfw_q;
  logic [31:0] m_num;
  logic [31:0] m_den;
  logic [31:0] m_ppr;
  logic [31:0] m_sw;
  logic [31:0] m_jerk;
  logic [31:0] m_lp;
  logic [31:0] m_interp;
  logic [31:0] m_pfw;
  logic [31:0] count_q;
  logic [PEND_W-1:0] pend_q;
  div_state_type state_q;

  assign req = wb_cyc_i & wb_stb_i;
  // writes land on the edge where the master sees ack
  assign wr = req & wb_we_i & ack_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req & ~ack_q) begin
      dat_q <= rd_data;
    end
  end

  assign m_num = merge(num_q, wb_dat_i, wb_sel_i);
  assign m_den = merge(den_q, wb_dat_i, wb_sel_i);
  assign m_ppr = merge(ppr_q, wb_dat_i, wb_sel_i);
  assign m_sw = merge({31'h0000_0000, sw_q}, wb_dat_i, wb_sel_i);
  assign m_jerk = merge({16'h0000, jerk_q}, wb_dat_i, wb_sel_i);
  assign m_lp = merge({16'h0000, lp_q}, wb_dat_i, wb_sel_i);
  assign m_interp = merge({16'h0000, interp_q}, wb_dat_i, wb_sel_i);
  assign m_pfw = merge({16'h0000, pfw_q}, wb_dat_i, wb_sel_i);

  // out-of-range writes are dropped, the old setting stays
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      num_q <= `GF_RST_NUM; // R9
      den_q <= `GF_RST_DEN; // R10
      ppr_q <= `GF_RST_PPR; // R11
      sw_q <= 1'b0; // R12
      jerk_q <= `GF_RST_TC; // R14
      lp_q <= `GF_RST_TC; // R15
      interp_q <= `GF_RST_TC; // R16
      pfw_q <= `GF_RST_PFW;
    end else if (wr) begin
      if (wb_adr_i == `GF_REG_NUM) begin
        if (in_rng(m_num, `GF_RATIO_MIN, `GF_RATIO_MAX)) num_q <= m_num; // R9
      end else if (wb_adr_i == `GF_REG_DEN) begin
        if (in_rng(m_den, `GF_RATIO_MIN, `GF_RATIO_MAX)) den_q <= m_den; // R10
      end else if (wb_adr_i == `GF_REG_PPR) begin
        if (in_rng(m_ppr, `GF_PPR_MIN, `GF_PPR_MAX)) ppr_q <= m_ppr; // R11
      end else if (wb_adr_i == `GF_REG_SW) begin
        if (m_sw[31:1] == 31'h0000_0000) sw_q <= m_sw[0]; // R12
      end else if (wb_adr_i == `GF_REG_JERK) begin
        if (in_rng(m_jerk, 32'h0, {16'h0000, `GF_JERK_MAX})) jerk_q <= m_jerk[15:0]; // R14
      end else if (wb_adr_i == `GF_REG_LP) begin
        if (in_rng(m_lp, 32'h0, {16'h0000, `GF_LP_MAX})) lp_q <= m_lp[15:0]; // R15
      end else if (wb_adr_i == `GF_REG_INTERP) begin
        if (in_rng(m_interp, 32'h0, {16'h0000, `GF_INTERP_MAX})) interp_q <= m_interp[15:0]; // R16
      end else if (wb_adr_i == `GF_REG_PFW) begin
        if (in_rng(m_pfw, 32'h0, {16'h0000, `GF_PFW_MAX})) pfw_q <= m_pfw[15:0];
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    if (wb_adr_i == `GF_REG_NUM) rd_data = num_q;
    else if (wb_adr_i == `GF_REG_DEN) rd_data = den_q;
    else if (wb_adr_i == `GF_REG_PPR) rd_data = ppr_q;
    else if (wb_adr_i == `GF_REG_SW) rd_data = {31'h0000_0000, sw_q};
    else if (wb_adr_i == `GF_REG_JERK) rd_data = {16'h0000, jerk_q};
    else if (wb_adr_i == `GF_REG_LP) rd_data = {16'h0000, lp_q};
    else if (wb_adr_i == `GF_REG_INTERP) rd_data = {16'h0000, interp_q};
    else if (wb_adr_i == `GF_REG_PFW) rd_data = {16'h0000, pfw_q};
    else if (wb_adr_i == `GF_REG_COUNT) rd_data = count_q; // R5 R8
    else if (wb_adr_i == `GF_REG_CMD) rd_data = 32'(cmd_pos_o);
    else if (wb_adr_i == `GF_REG_STAT) rd_data = {30'h0000_0000, pend_q != '0, state_q != DIV_IDLE};
  end

  // ************************************************
  // pin noise filter, pulse and direction
  // ************************************************
  logic [1:0] pin_raw;
  logic [1:0] pin_filt;
  logic [31:0] width_ns;

  assign pin_raw = {dir_i, pulse_i};
  assign width_ns = 32'(pfw_q) * `GF_WIDTH_STEP_NS; // R2

  for (genvar ch = 0; ch < 2; ch++) begin : g_pin
    logic s1_q;
    logic s2_q;
    logic f_q;
    logic [31:0] ns_q;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
      end else begin
        s1_q <= pin_raw[ch];
        s2_q <= s1_q;
      end
    end
    // a new level must persist a whole width, so short highs and
    // short lows both vanish
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        f_q <= 1'b0;
        ns_q <= 32'h0000_0000;
      end else if (s2_q == f_q) begin
        ns_q <= 32'h0000_0000; // R1
      end else if (ns_q + `GF_CLK_NS >= width_ns) begin
        f_q <= s2_q; // R19
        ns_q <= 32'h0000_0000;
      end else begin
        ns_q <= ns_q + `GF_CLK_NS; // R19
      end
    end
    assign pin_filt[ch] = f_q;
  end

  assign filt_pulse_o = pin_filt[0];
  assign filt_dir_o = pin_filt[1];

  // ************************************************
  // pulse counting and backlog
  // ************************************************
  logic last_q;
  logic rise;
  logic start;
  logic [PEND_W-1:0] pend_inc;
  logic [PEND_W-1:0] pend_dec;

  assign rise = pin_filt[0] & ~last_q; // R1
  assign start = (state_q == DIV_IDLE) && (pend_q != '0);
  assign pend_inc = rise ? (pin_filt[1] ? PEND_W'(1) : '1) : '0;
  assign pend_dec = start ? (pend_q[PEND_W-1] ? '1 : PEND_W'(1)) : '0;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_q <= 1'b0;
      pend_q <= '0;
      count_q <= 32'h0000_0000;
    end else begin
      last_q <= pin_filt[0];
      pend_q <= pend_q + pend_inc - pend_dec;
      count_q <= count_q + {{16{pend_inc[PEND_W-1]}}, 16'(pend_inc)}; // R5 R8
    end
  end

  assign pulse_count_o = count_q;

  // ************************************************
  // gear scaling divider, one pulse at a time
  // ************************************************
  logic [31:0] num_e;
  logic [31:0] den_e;
  logic [31:0] acc_q;
  logic [31:0] acc_e;
  logic [31:0] den_l_q;
  logic neg_q;
  logic [32:0] dvd_q;
  logic [32:0] rem_q;
  logic [32:0] quo_q;
  logic [5:0] bit_q;
  logic [32:0] trial;
  logic [POS_W-1:0] gear_q;

  // switch 0 scales by units-per-turn over pulses-per-turn
  assign num_e = sw_q ? num_q : `GF_UNITS_PER_REV; // R4 R6 R7
  assign den_e = sw_q ? den_q : ppr_q; // R4 R6 R7
  assign acc_e = (acc_q < den_e) ? acc_q : 32'h0000_0000;
  assign trial = {rem_q[31:0], dvd_q[32]};

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= DIV_IDLE;
      den_l_q <= 32'h0000_0001;
      neg_q <= 1'b0;
      dvd_q <= 33'h0_0000_0000;
      rem_q <= 33'h0_0000_0000;
      quo_q <= 33'h0_0000_0000;
      bit_q <= 6'h00;
    end else begin
      case (state_q)
        DIV_IDLE: begin
          if (start) begin
            neg_q <= pend_q[PEND_W-1];
            den_l_q <= den_e;
            // backward step divides num + den-1-acc, then mirrors
            dvd_q <= {1'b0, num_e} + {1'b0, pend_q[PEND_W-1] ? den_e - 32'h1 - acc_e : acc_e}; // R18
            rem_q <= 33'h0_0000_0000;
            quo_q <= 33'h0_0000_0000;
            bit_q <= 6'h21;
            state_q <= DIV_RUN;
          end
        end
        DIV_RUN: begin
          dvd_q <= {dvd_q[31:0], 1'b0};
          rem_q <= (trial >= {1'b0, den_l_q}) ? trial - {1'b0, den_l_q} : trial;
          quo_q <= {quo_q[31:0], trial >= {1'b0, den_l_q}};
          bit_q <= bit_q - 6'h01;
          if (bit_q == 6'h01) state_q <= DIV_DONE;
        end
        DIV_DONE: state_q <= DIV_IDLE;
        default: state_q <= DIV_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gear_q <= '0;
      acc_q <= 32'h0000_0000;
    end else if (state_q == DIV_DONE) begin
      gear_q <= neg_q ? gear_q - POS_W'(quo_q) : gear_q + POS_W'(quo_q); // R7
      acc_q <= neg_q ? den_l_q - 32'h1 - rem_q[31:0] : rem_q[31:0]; // R18
    end
  end

  assign gear_pos_o = gear_q;

  // ************************************************
  // smoothing: interpolation, jerk, low-pass
  // ************************************************
  logic [TW-1:0] tick_q;
  logic tick;
  logic [POS_W-1:0] stg_x [3];
  logic [POS_W-1:0] stg_y [3];
  logic [15:0] stg_tc [3];
  logic [2:0] stg_on;

  assign tick = (tick_q == TW'(MS_CYCLES - 1));

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_q <= '0;
    end else if (tick) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + TW'(1);
    end
  end

  assign stg_x[0] = gear_q;
  assign stg_x[1] = (ctrl_mode_i == MODE_TRAJ) ? traj_pos_i : stg_y[0];
  assign stg_x[2] = stg_y[1];
  assign stg_tc[0] = interp_q; // R16
  assign stg_tc[1] = jerk_q; // R14
  assign stg_tc[2] = lp_q; // R15
  assign stg_on[0] = (ctrl_mode_i == MODE_PULSE); // R17
  assign stg_on[1] = (ctrl_mode_i == MODE_TRAJ); // R14
  assign stg_on[2] = 1'b1; // R15

  // first-order lag per stage; cascading gives the S profile
  for (genvar k = 0; k < 3; k++) begin : g_stage
    logic signed [POS_W:0] diff;
    logic signed [POS_W:0] step;
    logic [POS_W-1:0] y_q;
    assign diff = $signed({stg_x[k][POS_W-1], stg_x[k]})
                - $signed({y_q[POS_W-1], y_q});
    always_comb begin
      step = diff / $signed({1'b0, stg_tc[k]});
      // integer steps would stall short of target, so creep by one
      if (step == '0 && diff != '0) begin
        step = diff[POS_W] ? '1 : (POS_W+1)'(1);
      end
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        y_q <= '0;
      end else if (!stg_on[k] || stg_tc[k] == 16'h0000) begin
        y_q <= stg_x[k]; // R13
      end else if (tick) begin
        y_q <= y_q + POS_W'(step); // R13
      end
    end
    assign stg_y[k] = y_q;
  end

  assign cmd_pos_o = stg_y[2];

endmodule
`default_nettype wire

// ==== sim/gear_filter_chk.sv ====
/*
  Port checker of the pulse command gear filter.
  Assumes full-word writes to the filter width register.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gear_filter_map.svh"
module gear_filter_chk (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pulse_i,
  input wire logic filt_pulse_o,
  input wire logic filt_dir_o,
  input wire logic [31:0] pulse_count_o
);
  // ****
  // shadow width and phase lengths
  // ****
  logic [31:0] width_q;
  logic [31:0] hi_q;
  logic [31:0] lo_q;
  logic last_q;
  logic [31:0] need_w;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  assign need_w = (width_q == 32'h0) ? 32'h1 : (width_q * 32'h5 + 32'h1) >> 1;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      width_q <= 32'h2;
    end else if (wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == `GF_REG_PFW && wb_dat_i <= 32'h7D00) begin
      width_q <= wb_dat_i;
    end
  end
  // last completed run kept, the synchroniser lags the pin
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hi_q <= 32'h0;
      lo_q <= 32'h0;
      last_q <= 1'b0;
    end else begin
      last_q <= pulse_i;
      if (pulse_i) begin
        hi_q <= last_q ? hi_q + 32'h1 : 32'h1;
      end else begin
        lo_q <= last_q ? 32'h1 : lo_q + 32'h1;
      end
    end
  end
  // ****
  // properties
  // ****
  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  property count_step_p(logic dv, logic [31:0] dl);
    $rose(filt_pulse_o) && filt_dir_o == dv |=> pulse_count_o == $past(pulse_count_o) + dl;
  endproperty
  ack_late_a: assert property (wb_req_s |=> wb_ack_o) else $error("no ack after request");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > `GF_REG_STAT |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  count_up_a: assert property (count_step_p(1'b1, 32'h1)) else $error("forward pulse not counted");
  count_down_a: assert property (count_step_p(1'b0, 32'hFFFF_FFFF)) else $error("reverse pulse not counted");
  count_hold_a: assert property (!$rose(filt_pulse_o) |=> $stable(pulse_count_o)) else $error("count moved");
  high_width_a: assert property ($rose(filt_pulse_o) |-> hi_q >= need_w) else $error("short high passed");
  low_width_a: assert property ($fell(filt_pulse_o) |-> lo_q >= need_w) else $error("short low passed");
endmodule
bind pulse_command_gear_filter gear_filter_chk chk_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pulse_i(pulse_i), .filt_pulse_o(filt_pulse_o),
  .filt_dir_o(filt_dir_o), .pulse_count_o(pulse_count_o));
`default_nettype wire

// ==== sim/pulse_host_model.sv ====
/*
  Host controller sending pulse trains.
  Assumes calls start just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module pulse_host_model (
  input wire logic clk_i,
  output logic pulse_o,
  output logic dir_o
);
  initial begin
    pulse_o = 1'b0;
    dir_o = 1'b1;
  end
  // phases in cycles; direction settles before the first pulse
  task automatic send(input int n, input int h, input int l, input logic d);
    dir_o <= d;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      pulse_o <= 1'b1;
      repeat (h) @(posedge clk_i);
      pulse_o <= 1'b0;
      repeat (l) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ==== sim/pulse_command_gear_filter_tb_top.sv ====
/*
  Self-checking bench: registers, pulse filter, gear model, smoothing.
  Assumes the checker is bound and the host model compiled.
*/
`timescale 1ns/10ps
`default_nettype none
module pulse_command_gear_filter_tb_top;
  import gear_filter_pkg::*;
  logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, ack, fp, fd, pin, dirp;
  logic [7:0] adr = 0;
  logic [31:0] wd = 0, rdat, gpos, cpos, pcnt, s;
  logic [31:0] traj = 0;
  ctrl_mode_type mode = MODE_PULSE;
  int fail_count = 0, cmp_count = 0, seed = 85821, cnt = 0;
  longint gp = 0, rm = 0, num = 1048576, den = 10000, ppr = 10000, sw = 0;
  logic [31:0] rv[8] = '{32'h100000, 32'h2710, 32'h2710, 0, 32'hA, 32'hA, 32'hA, 32'h2};
  logic [31:0] bad[8] = '{0, 0, 32'hC7, 2, 32'hFB, 32'h3E9, 32'hFB, 32'h7D01};
  logic [31:0] good[8] = '{32'h7FFFFFFF, 32'h7FFFFFFF, 32'hC8, 1, 32'hFA, 32'h3E8, 32'hFA, 32'h7D00};
  pulse_command_gear_filter #(.MS_CYCLES(10), .POS_W(32), .PEND_W(16)) dut_u (.ref_clk_i(clk),
    .rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd),
    .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .pulse_i(pin), .dir_i(dirp), .ctrl_mode_i(mode),
    .traj_pos_i(traj), .filt_pulse_o(fp), .filt_dir_o(fd), .gear_pos_o(gpos), .cmd_pos_o(cpos),
    .pulse_count_o(pcnt));
  pulse_host_model host_u (.clk_i(clk), .pulse_o(pin), .dir_o(dirp));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] v, logic [31:0] e);
    cmp_count++;
    if (v !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d;
    i = 0;
    do begin @(posedge clk); i++; end while (ack !== 1'b1 && i < 50);
    if (i >= 50) begin fail_count++; stop_test; end
    s = rdat;
    cyc <= 0; stb <= 0;
  endtask
  // model of accepted pulses; divider keeps the remainder, reverse steps round down
  task automatic acc(int n, bit f);
    longint nu, de, k;
    nu = sw ? num : 1048576;
    de = sw ? den : ppr;
    for (int i = 0; i < n; i++) begin
      cnt += f ? 1 : -1;
      if (rm >= de) rm = 0;
      if (f) begin
        rm += nu;
        gp += rm / de;
        rm = rm % de;
      end else begin
        rm -= nu;
        k = (de - 1 - rm) / de;
        gp -= k;
        rm += k * de;
      end
    end
  endtask
  task automatic check_pos(bit g);
    int i;
    repeat (60) @(posedge clk);
    i = 0;
    do begin bus(0, 8'h28, 0); i++; end while (s[1:0] !== 2'b00 && i < 400);
    if (i >= 400) begin fail_count++; stop_test; end
    repeat (4) @(posedge clk);
    bus(0, 8'h20, 0);
    chk("count", s, cnt);
    if (g) chk("gear", gpos, 32'(gp));
    if (g) chk("cmd", cpos, 32'(gp));
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1;
    for (int i = 0; i < 8; i++) begin
      bus(0, 8'(4 * i), 0);
      chk("reset", s, rv[i]);
      bus(1, 8'(4 * i), bad[i]);
      bus(0, 8'(4 * i), 0);
      chk("refused", s, rv[i]);
      bus(1, 8'(4 * i), good[i]);
      bus(0, 8'(4 * i), 0);
      chk("edge", s, good[i]);
      bus(1, 8'(4 * i), rv[i]);
    end
    bus(0, 8'h30, 0);
    chk("unmapped", s, 0);
    $display("test registers done");
    bus(1, 8'h14, 0);
    bus(1, 8'h18, 0);
    bus(1, 8'h1C, 10);
    host_u.send(3, 32, 32, 1); acc(3, 1);
    host_u.send(2, 18, 32, 1); acc(0, 1);
    host_u.send(2, 32, 18, 1); acc(1, 1);
    check_pos(1);
    bus(1, 8'h1C, 0);
    host_u.send(3, 3, 3, 1); acc(3, 1);
    check_pos(1);
    $display("test filter done");
    for (int k = 0; k < 4; k++) begin
      sw = k & 1;
      num = 1 + {$random(seed)} % 1000;
      den = 1 + {$random(seed)} % 1000;
      ppr = 200 + {$random(seed)} % 1000;
      bus(1, 8'h00, 32'(num));
      bus(1, 8'h04, 32'(den));
      bus(1, 8'h08, 32'(ppr));
      bus(1, 8'h0C, 32'(sw));
      i_send(1 + {$random(seed)} % 4);
      check_pos(1);
    end
    host_u.send(2, 4, 4, 0); acc(2, 0);
    check_pos(1);
    $display("test gear done");
    bus(1, 8'h18, 10);
    bus(1, 8'h10, 0);
    mode <= MODE_TRAJ;
    traj <= 0;
    repeat (5) @(posedge clk);
    chk("bypass", cpos, 0);
    bus(1, 8'h14, 4);
    traj <= 40;
    repeat (3) @(posedge clk);
    chk("smooth", {31'h0, cpos === 32'd40}, 0);
    repeat (1200) @(posedge clk);
    chk("settled", cpos, 40);
    $display("test smoothing done");
    bus(1, 8'h0C, 0);
    sw = 0;
    bus(1, 8'h14, 0);
    mode <= MODE_PULSE;
    i_send(2);
    repeat (100) @(posedge clk);
    chk("interp lag", {31'h0, cpos === 32'(gp)}, 0);
    repeat (1500) @(posedge clk);
    check_pos(1);
    $display("test interpolation done");
    stop_test;
  end
  task automatic i_send(int n);
    host_u.send(n, 4, 4, 1);
    acc(n, 1);
  endtask
endmodule
`default_nettype wire
